// ===== hw/phy_mgmt_pkg.sv
// Constants for the PHY management control and status register block
package phy_mgmt_pkg;
    // Register addresses on the management frame
    localparam logic [4:0]  REG_CONTROL     = 5'h00;
    localparam logic [4:0]  REG_STATUS      = 5'h01;
    // Control register field positions
    localparam int          CTL_AN_EN       = 12;
    localparam int          CTL_AN_RESTART  = 9;
    localparam int          CTL_DUPLEX      = 8;
    localparam int          CTL_COL_TEST    = 7;
    // Status register field positions
    localparam int          STS_T4_CAP      = 15;
    localparam int          STS_CAP_MSB     = 14;
    localparam int          STS_CAP_LSB     = 11;
    localparam int          STS_PRE_SUPP    = 6;
    localparam int          STS_AN_DONE     = 5;
    // Reset values and fixed status bit values
    localparam logic        RST_AN_EN       = 1'h1;
    localparam logic        RST_AN_RESTART  = 1'h0;
    localparam logic        RST_DUPLEX      = 1'h1;
    localparam logic        RST_COL_TEST    = 1'h0;
    localparam logic        VAL_T4_CAP      = 1'h0;
    localparam logic        VAL_PRE_SUPP    = 1'h1;
    // Management frame layout
    localparam logic [1:0]  OP_READ         = 2'h2;
    localparam logic [1:0]  OP_WRITE        = 2'h1;
    localparam logic [2:0]  START_PATTERN   = 3'h5;
    localparam logic [4:0]  HDR_LAST        = 5'h0b;
    localparam logic [4:0]  DATA_LAST       = 5'h0f;
    // Collision test timing in bit times, and clock periods in ns
    localparam int          COL_ON_BT       = 512;
    localparam int          COL_OFF_BT      = 4;
    localparam int          BT_100_NS       = 10;
    localparam int          SYS_CLK_NS      = 20;
    // Longest allowed lag, rounded down; the path below uses one cycle
    localparam int          COL_OFF_CYCLES  = (COL_OFF_BT * BT_100_NS) / SYS_CLK_NS;
    localparam int          COL_ON_CYCLES   = (COL_ON_BT * BT_100_NS) / SYS_CLK_NS;
    // Frame decoder states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HDR  = 2'b01,
        ST_TA   = 2'b10,
        ST_DATA = 2'b11
    } frame_state_t;
endpackage

// ===== hw/phy_mgmt_control_status_regs.sv
// Control and status registers of the PHY, reached by management frames
// Summary of operation
// RULE1 - Writing one to the restart bit while negotiation is enabled starts a new negotiation.
// RULE2 - With negotiation disabled the restart bit ignores writes and is read only.
// RULE3 - Writing zero to the restart bit never aborts a negotiation in progress.
// RULE4 - The restart bit resets to zero and clears itself when negotiation finishes.
// RULE5 - The duplex bit selects full (1) or half (0), acts only with negotiation off, resets from a pin; here it drives o_duplex_full always.
// RULE6 - With collision test set, COL rises within 512 bit times of TXEN rising.
// RULE7 - With collision test set, COL follows TXEN falling within 4 bit times.
// RULE8 - The controller writes zeros to control bits 6..0 and ignores them on read.
// RULE9 - The 100Base-T4 capability bit always reads zero.
// RULE10 - The four speed/duplex capability bits read one unless strapping disables that mode.
// RULE11 - The preamble suppression bit reads one and frames without preamble are accepted.
// RULE12 - The negotiation complete bit reads one only after negotiation has finished.
// RULE13 - The negotiation complete bit reads zero whenever negotiation is disabled.
// RULE14 - The negotiation enable bit switches negotiation on or off and resets to one.
// RULE15 - Both registers are 16 bits at addresses 0 and 1, reached by clause 22 frames.
`timescale 1ns/100ps
module phy_mgmt_control_status_regs
    import phy_mgmt_pkg::*;
(
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // Management interface
    input  wire logic        i_mdc,
    input  wire logic        i_mdio,
    output logic             o_mdio,
    output logic             o_mdio_oe,
    input  wire logic [4:0]  i_phy_addr,
    // Configuration straps
    input  wire logic        i_strap_duplex,
    input  wire logic [3:0]  i_strap_cap,
    // Negotiation engine
    output logic             o_an_enable,
    output logic             o_an_restart,
    input  wire logic        i_an_done,
    output logic             o_duplex_full,
    // MII collision path
    input  wire logic        i_tx_en,
    input  wire logic        i_col_line,
    output logic             o_col
);

    logic              mdc_prev_ff;
    logic              mdc_rise;
    frame_state_t      state_ff;
    logic [2:0]        hist_ff;
    logic [4:0]        cnt_ff;
    logic [11:0]       hdr_ff;
    logic [11:0]       nxt_hdr;
    logic [15:0]       shift_ff;
    logic [15:0]       nxt_word;
    logic              is_read_ff;
    logic              wr_commit;
    logic [15:0]       wr_data;
    logic [4:0]        wr_reg;
    logic [15:0]       rd_data;
    logic              init_done_ff;
    logic              an_en_ff;
    logic              restart_ff;
    logic              restart_pulse_ff;
    logic              duplex_ff;
    logic              col_test_ff;
    logic              an_complete_ff;
    logic              col_ff;
    logic              restart_req;

    // MDC is taken as synchronous; its rising edge qualifies every bit
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            mdc_prev_ff <= 1'h0;
        end else begin
            mdc_prev_ff <= i_mdc;
        end
    end
    assign mdc_rise = i_mdc & ~mdc_prev_ff;
    assign nxt_hdr  = {hdr_ff[10:0], i_mdio};
    assign nxt_word = {shift_ff[14:0], i_mdio};

    // Read image of the two registers; bits outside this block read zero
    always_comb begin
        rd_data = 16'h0000;
        if (nxt_hdr[4:0] == REG_CONTROL) begin // see RULE15
            rd_data[CTL_AN_EN]      = an_en_ff;
            rd_data[CTL_AN_RESTART] = restart_ff;
            rd_data[CTL_DUPLEX]     = duplex_ff;
            rd_data[CTL_COL_TEST]   = col_test_ff; // see RULE8
        end else if (nxt_hdr[4:0] == REG_STATUS) begin
            rd_data[STS_T4_CAP]                  = VAL_T4_CAP; // see RULE9
            rd_data[STS_CAP_MSB:STS_CAP_LSB]     = i_strap_cap; // see RULE10
            rd_data[STS_PRE_SUPP]                = VAL_PRE_SUPP; // see RULE11
            rd_data[STS_AN_DONE]                 = an_complete_ff & an_en_ff; // see RULE13
        end
    end

    // Frame decoder; a start needs only one idle bit, so no preamble is required
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state_ff   <= ST_IDLE;
            hist_ff    <= 3'h0;
            cnt_ff     <= 5'h00;
            hdr_ff     <= 12'h000;
            shift_ff   <= 16'h0000;
            is_read_ff <= 1'h0;
            o_mdio     <= 1'h1;
            o_mdio_oe  <= 1'h0;
        end else if (mdc_rise) begin
            unique case (state_ff)
                ST_IDLE: begin
                    hist_ff <= {hist_ff[1:0], i_mdio};
                    if ({hist_ff[1:0], i_mdio} == START_PATTERN) begin // see RULE11
                        state_ff <= ST_HDR;
                        cnt_ff   <= 5'h00;
                    end
                end
                ST_HDR: begin
                    hdr_ff <= nxt_hdr;
                    cnt_ff <= cnt_ff + 5'h01;
                    if (cnt_ff == HDR_LAST) begin
                        state_ff   <= ST_TA;
                        cnt_ff     <= 5'h00;
                        // Snapshot taken here so the word read is self-consistent
                        shift_ff   <= rd_data;
                        is_read_ff <= (nxt_hdr[11:10] == OP_READ) &&
                                      (nxt_hdr[9:5] == i_phy_addr); // see RULE15
                    end
                end
                ST_TA: begin
                    cnt_ff <= cnt_ff + 5'h01;
                    // Line stays high unless this device answers a read
                    if (cnt_ff == 5'h00) begin
                        o_mdio    <= ~is_read_ff;
                        o_mdio_oe <= is_read_ff;
                    end else begin
                        state_ff <= ST_DATA;
                        cnt_ff   <= 5'h00;
                        o_mdio   <= shift_ff[15] | ~is_read_ff;
                        if (is_read_ff) begin
                            shift_ff <= {shift_ff[14:0], 1'h0};
                        end
                    end
                end
                ST_DATA: begin
                    cnt_ff <= cnt_ff + 5'h01;
                    if (is_read_ff) begin
                        o_mdio   <= shift_ff[15];
                        shift_ff <= {shift_ff[14:0], 1'h0};
                    end else begin
                        shift_ff <= nxt_word;
                    end
                    if (cnt_ff == DATA_LAST) begin
                        state_ff  <= ST_IDLE;
                        hist_ff   <= 3'h0;
                        o_mdio    <= 1'h1;
                        o_mdio_oe <= 1'h0;
                    end
                end
            endcase
        end
    end

    assign wr_commit = mdc_rise && (state_ff == ST_DATA) && (cnt_ff == DATA_LAST) &&
                       (hdr_ff[11:10] == OP_WRITE) && (hdr_ff[9:5] == i_phy_addr);
    assign wr_data   = nxt_word;
    assign wr_reg    = hdr_ff[4:0];
    // Only the enable held before the write counts, so one write cannot enable and restart
    assign restart_req = wr_commit && (wr_reg == REG_CONTROL) &&
                         wr_data[CTL_AN_RESTART] && an_en_ff; // see RULE1 see RULE2

    // Negotiation enable, duplex and collision test settings
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            init_done_ff <= 1'h0;
            an_en_ff     <= RST_AN_EN; // see RULE14
            duplex_ff    <= RST_DUPLEX;
            col_test_ff  <= RST_COL_TEST;
        end else begin
            init_done_ff <= 1'h1;
            if (!init_done_ff) begin
                duplex_ff <= i_strap_duplex; // see RULE5
            end else if (wr_commit && wr_reg == REG_CONTROL) begin
                an_en_ff    <= wr_data[CTL_AN_EN]; // see RULE14
                duplex_ff   <= wr_data[CTL_DUPLEX];
                col_test_ff <= wr_data[CTL_COL_TEST];
            end
        end
    end

    // Restart bit: set by a qualified write, cleared only by the engine finishing
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            restart_ff       <= RST_AN_RESTART; // see RULE4
            restart_pulse_ff <= 1'h0;
        end else begin
            restart_pulse_ff <= restart_req; // see RULE1
            if (restart_req) begin
                restart_ff <= 1'h1; // see RULE3
            end else if (i_an_done) begin
                restart_ff <= 1'h0; // see RULE4
            end
        end
    end

    // Completion flag; a done in the same cycle as a restart request loses to it
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            an_complete_ff <= 1'h0;
        end else if (restart_req || !an_en_ff) begin
            an_complete_ff <= 1'h0; // see RULE13
        end else if (i_an_done) begin
            an_complete_ff <= 1'h1; // see RULE12
        end
    end

    // One cycle of lag meets both the 512 and 4 bit time limits at either speed
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            col_ff <= 1'h0;
        end else begin
            col_ff <= col_test_ff ? i_tx_en : i_col_line; // see RULE6 see RULE7
        end
    end

    assign o_an_enable   = an_en_ff;
    assign o_an_restart  = restart_pulse_ff;
    assign o_duplex_full = duplex_ff; // see RULE5
    assign o_col         = col_ff;

endmodule // phy_mgmt_control_status_regs

// ===== tb/phy_mgmt_chk.sv
// Concurrent checks on the register block's ports
`timescale 1ns/100ps
module phy_mgmt_chk (
    // Watched ports
    input logic       i_sys_clk,
    input logic       i_rst,
    input logic       i_mdc,
    input logic       i_mdio,
    input logic       o_mdio,
    input logic       o_mdio_oe,
    input logic [4:0] i_phy_addr,
    input logic       i_strap_duplex,
    input logic [3:0] i_strap_cap,
    input logic       o_an_enable,
    input logic       o_an_restart,
    input logic       i_an_done,
    input logic       o_duplex_full,
    input logic       i_tx_en,
    input logic       i_col_line,
    input logic       o_col
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    logic       mdc_q;
    logic [4:0] rises;
    // Rises counted only while driving, so a read answer is exactly TA2 plus 16 bits
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            mdc_q <= 1'b0;
            rises <= 5'h00;
        end else begin
            mdc_q <= i_mdc;
            if (!o_mdio_oe) rises <= 5'h00;
            else if (i_mdc && !mdc_q) rises <= rises + 5'h01;
        end
    end
    sequence s_one_cycle;
        o_an_restart ##1 !o_an_restart;
    endsequence
    sequence s_ta_low;
        $rose(o_mdio_oe) ##0 !o_mdio;
    endsequence
    AST_RESTART_PULSE: assert property (o_an_restart |-> s_one_cycle)
        else $error("restart pulse longer than one cycle");
    AST_RESTART_AN_ON: assert property (o_an_restart |-> o_an_enable)
        else $error("restart pulse with negotiation off");
    AST_COL_SRC: assert property (o_col == $past(i_tx_en) || o_col == $past(i_col_line))
        else $error("collision output from no source");
    AST_IDLE_HIGH: assert property (!o_mdio_oe |-> o_mdio)
        else $error("data out not high while released");
    AST_TA_ZERO: assert property ($rose(o_mdio_oe) |-> s_ta_low)
        else $error("turnaround bit not zero");
    AST_WORD_LEN: assert property ($fell(o_mdio_oe) |-> rises == 5'h11)
        else $error("read answer length wrong");
    AST_DUPLEX_LOAD: assert property ($fell(i_rst) |=> o_duplex_full == $past(i_strap_duplex))
        else $error("duplex not loaded from strap");
    AST_AN_EN_RST: assert property ($fell(i_rst) |-> o_an_enable)
        else $error("negotiation enable not one after reset");
endmodule // phy_mgmt_chk
bind phy_mgmt_control_status_regs phy_mgmt_chk u_chk (.*);

// ===== tb/smc_model.sv
// Station management controller model sending clause 22 frames
`timescale 1ns/100ps
module smc_model
    import phy_mgmt_pkg::*;
(
    // Clock
    input  logic i_sys_clk,
    // Device side of the wire
    input  logic i_mdio,
    input  logic i_mdio_oe,
    output logic o_mdc,
    output logic o_mdio
);
    logic drv = 1'b0;
    logic dq  = 1'b1;
    initial o_mdc = 1'b0;
    // Pull-up: the line reads one once both sides let go
    assign o_mdio = i_mdio_oe ? i_mdio : (drv ? dq : 1'b1);
    // One idle one then start, no preamble; MDC stands low between frames
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [32:0] w;
        w = {START_PATTERN, op, pa, ra, 2'b10, wd};
        for (int i = 32; i >= 0; i--) begin
            dq = w[i];
            drv = (op != OP_READ) || (i > 17);
            o_mdc = 1'b0;
            repeat (2) @(posedge i_sys_clk);
            #1;
            if (i < 16) rd[i] = o_mdio;
            o_mdc = 1'b1;
            repeat (2) @(posedge i_sys_clk);
            #1;
        end
        drv = 1'b0;
        o_mdc = 1'b0;
    endtask
endmodule // smc_model

// ===== tb/tb_phy_mgmt_control_status_regs.sv
// Self-checking bench for the PHY control and status registers
`timescale 1ns/100ps
module tb_phy_mgmt_control_status_regs
    import phy_mgmt_pkg::*;
;
    localparam logic [4:0] PHY_AD = 5'h03;
    logic i_sys_clk, i_rst, i_mdc, i_mdio, o_mdio, o_mdio_oe, i_strap_duplex, o_an_enable;
    logic o_an_restart, i_an_done, o_duplex_full, i_tx_en, i_col_line, o_col;
    logic [4:0]  i_phy_addr;
    logic [3:0]  i_strap_cap;
    logic [15:0] rd;
    int errors = 0;
    int n_checks = 0;
    int restarts = 0;
    phy_mgmt_control_status_regs dut (.*);
    smc_model u_smc (.i_sys_clk(i_sys_clk), .i_mdio(o_mdio), .i_mdio_oe(o_mdio_oe),
                     .o_mdc(i_mdc), .o_mdio(i_mdio));
    always #10 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) if (o_an_restart === 1'b1) restarts++;
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        u_smc.frame(OP_WRITE, PHY_AD, ra, d, rd);
    endtask
    task automatic rdc(input logic [4:0] ra, input logic [15:0] exp, input string what);
        u_smc.frame(OP_READ, PHY_AD, ra, 16'h0000, rd);
        check(what, exp, rd);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Frames are slow; this bound only catches a stuck run
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        errors++;
        end_of_test();
    end
    initial begin
        {i_sys_clk, i_strap_duplex, i_an_done, i_tx_en, i_col_line} = 5'h00;
        i_rst = 1'b1;
        i_phy_addr = PHY_AD;
        i_strap_cap = 4'hb;
        cyc(2);
        i_rst = 1'b0;
        cyc(2);
        check("duplex_out", 16'h0000, {15'h0, o_duplex_full});
        rdc(REG_CONTROL, 16'h1000, "ctl_reset");
        rdc(REG_STATUS, 16'h5840, "sts_reset");
        $display("test reset done");
        wr(REG_CONTROL, 16'h1200);
        check("restarts", 16'h0001, 16'(restarts));
        rdc(REG_CONTROL, 16'h1200, "ctl_restart");
        wr(REG_CONTROL, 16'h1000);
        rdc(REG_CONTROL, 16'h1200, "ctl_keep");
        rdc(REG_STATUS, 16'h5840, "sts_busy");
        i_an_done = 1'b1;
        cyc(1);
        i_an_done = 1'b0;
        rdc(REG_CONTROL, 16'h1000, "ctl_selfclr");
        rdc(REG_STATUS, 16'h5860, "sts_done");
        $display("test restart done");
        wr(REG_CONTROL, 16'h0100);
        rdc(REG_STATUS, 16'h5840, "sts_an_off");
        check("duplex_out", 16'h0001, {15'h0, o_duplex_full});
        check("an_enable", 16'h0000, {15'h0, o_an_enable});
        wr(REG_CONTROL, 16'h0300);
        rdc(REG_CONTROL, 16'h0100, "ctl_ro_restart");
        check("restarts", 16'h0001, 16'(restarts));
        i_strap_cap = 4'h6;
        rdc(REG_STATUS, 16'h3040, "sts_straps");
        $display("test an_off done");
        wr(REG_CONTROL, 16'h0180);
        i_tx_en = 1'b1;
        cyc(2);
        check("col_on", 16'h0001, {15'h0, o_col});
        i_tx_en = 1'b0;
        cyc(2);
        check("col_off", 16'h0000, {15'h0, o_col});
        wr(REG_CONTROL, 16'h0100);
        i_tx_en = 1'b1;
        cyc(2);
        check("col_normal", 16'h0000, {15'h0, o_col});
        i_col_line = 1'b1;
        cyc(2);
        check("col_line", 16'h0001, {15'h0, o_col});
        i_col_line = 1'b0;
        i_tx_en = 1'b0;
        $display("test collision done");
        rdc(5'h02, 16'h0000, "unmapped");
        u_smc.frame(OP_READ, PHY_AD ^ 5'h01, REG_CONTROL, 16'h0000, rd);
        check("other_addr", 16'hffff, rd);
        $display("test access done");
        i_strap_duplex = 1'b1;
        i_rst = 1'b1;
        cyc(2);
        i_rst = 1'b0;
        cyc(2);
        check("an_enable", 16'h0001, {15'h0, o_an_enable});
        check("duplex_out", 16'h0001, {15'h0, o_duplex_full});
        rdc(REG_CONTROL, 16'h1100, "ctl_rerst");
        rdc(REG_STATUS, 16'h3040, "sts_rerst");
        $display("test mid reset done");
        end_of_test();
    end
endmodule // tb_phy_mgmt_control_status_regs
